/* verilog/fbled_regs.svh */
// register offsets, field positions, reset values and timing counts of the lamp block
`ifndef FBLED_REGS_SVH
`define FBLED_REGS_SVH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define FBLED_OFS_CTRL      8'h00
`define FBLED_OFS_ERR_STAT  8'h04
`define FBLED_OFS_IRQ_MASK  8'h08
`define FBLED_OFS_LAMP_STAT 8'h0c

// ***************************************************************
// field positions and widths
// ***************************************************************
`define FBLED_CTRL_STATE_LSB 0
`define FBLED_CTRL_STATE_W   3
`define FBLED_CTRL_APPFAIL   3
`define FBLED_ERR_W          5
`define FBLED_LAMP_RUN_G     0
`define FBLED_LAMP_RUN_R     1
`define FBLED_LAMP_ERR_R     2
`define FBLED_LAMP_PASSIVE   3
`define FBLED_LAMP_LINK_LSB  8

// ***************************************************************
// reset values
// ***************************************************************
`define FBLED_CTRL_RST 4'h0
`define FBLED_ERR_RST  5'h00
`define FBLED_MASK_RST 5'h00

// ***************************************************************
// bus responses
// ***************************************************************
`define FBLED_RESP_OKAY   2'b00
`define FBLED_RESP_SLVERR 2'b10

// ***************************************************************
// pattern timing: one tick, counted in ticks per frame
// ***************************************************************
`define FBLED_CLK_MHZ      100
`define FBLED_TICK_MS      50
`define FBLED_TICK_CYCLES  (`FBLED_TICK_MS * 1000 * `FBLED_CLK_MHZ)
`define FBLED_FRAME_TICKS  5'd24
`define FBLED_ON_TICKS     5'd4
`define FBLED_SECOND_ON    5'd8
`define FBLED_SECOND_OFF   5'd12

`endif

/* verilog/fbled_pkg.sv */
// types shared by the fieldbus slave lamp block
package fbled_pkg;

   // slave protocol state, gray coded along init -> preop -> safeop -> op
   typedef enum logic [2:0] {
      FBLED_INIT   = 3'b000,
      FBLED_PREOP  = 3'b001,
      FBLED_SAFEOP = 3'b011,
      FBLED_OP     = 3'b010,
      FBLED_BOOT   = 3'b110
   } fbled_al_state_t;

   // periodic lamp patterns
   typedef struct packed {
      logic flicker;
      logic dflash;
      logic sflash;
      logic blink;
   } fbled_pat_t;

   // sticky error conditions, most severe in the top bit
   typedef struct packed {
      logic fatal;
      logic boot_err;
      logic wd_tmo;
      logic unsol;
      logic inv_cfg;
   } fbled_err_t;

endpackage

/* verilog/fbled_pattern_gen.sv */
// pattern generator: blink, single flash, double flash and flicker from the system clock
`timescale 1ns/1ps
`default_nettype none
`include "fbled_regs.svh"

module fbled_pattern_gen
   import fbled_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `FBLED_TICK_CYCLES
) (
   // clock and reset
   input  wire logic   aclk,
   input  wire logic   aresetn,
   // patterns
   output fbled_pat_t  pat,
   output logic        tick
);

   logic [31:0] pre_ff;
   logic [4:0]  step_ff;
   fbled_pat_t  pat_ff;
   logic        tick_ff;
   logic        tick_now;

   assign tick_now = (pre_ff == 32'(TICK_CYCLES - 1));

   // ***************************************************************
   // prescaler and frame step
   // ***************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_ff  <= 32'h0;
         step_ff <= 5'h00;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= tick_now;
         if (tick_now) begin
            pre_ff <= 32'h0;
            if (step_ff == `FBLED_FRAME_TICKS - 5'd1) begin
               step_ff <= 5'h00;
            end else begin
               step_ff <= step_ff + 5'd1;
            end
         end else begin
            pre_ff <= pre_ff + 32'h1;
         end
      end
   end

   // ***************************************************************
   // pattern decode, registered
   // ***************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pat_ff <= '0;
      end else begin
         pat_ff.blink   <= ((step_ff / `FBLED_ON_TICKS) % 5'd2) == 5'd0;
         pat_ff.sflash  <= step_ff < `FBLED_ON_TICKS;
         pat_ff.dflash  <= (step_ff < `FBLED_ON_TICKS) ||
                           ((step_ff >= `FBLED_SECOND_ON) &&
                            (step_ff < `FBLED_SECOND_OFF));
         pat_ff.flicker <= step_ff[0];
      end
   end

   assign pat  = pat_ff;
   assign tick = tick_ff;

endmodule

`default_nettype wire

/* verilog/fbled_top.sv */
// fieldbus slave status lamps with an axi4-lite register slave
// Functional notes
// - run lamp dark in init state, and with no power.
// - run lamp steady green in operational state.
// - run lamp blinks green in pre-operational state.
// - run lamp single-flashes green in safe-operational state.
// - run lamp flickers in boot state.
// - fatal or controller failure: both lamps red, bus interface passive.
// - error lamp dark with no error, and with no power.
// - invalid settings on master state request blink error lamp red.
// - autonomous local state change gives single red flash.
// - sync manager watchdog expiry gives double red flash.
// - booting error flickers the error lamp.
// - link lamp dark without link on its port, or with no power.
// - link lamp steady green with link and no traffic.
// - link lamp flickers green with link and traffic.
`timescale 1ns/1ps
`default_nettype none
`include "fbled_regs.svh"

module fbled_top
   import fbled_pkg::*;
#(
   parameter int unsigned NPORTS      = 2,
   parameter int unsigned ADDR_W      = 8,
   parameter int unsigned TICK_CYCLES = `FBLED_TICK_CYCLES
) (
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // axi4-lite read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // error events from the protocol logic, one-cycle pulses
   input  wire logic              evt_inv_cfg,
   input  wire logic              evt_unsol,
   input  wire logic              evt_wd_tmo,
   input  wire logic              evt_boot_err,
   input  wire logic              evt_fatal,
   // phy status pins per port
   input  wire logic [NPORTS-1:0] link_pin,
   input  wire logic [NPORTS-1:0] act_pin,
   // lamps and bus state
   output logic                   run_green,
   output logic                   run_red,
   output logic                   err_red,
   output logic [NPORTS-1:0]      link_green,
   output logic                   bus_passive,
   output logic                   irq
);

   // ***************************************************************
   // declarations
   // ***************************************************************
   logic                 awready_ff;
   logic                 wready_ff;
   logic                 bvalid_ff;
   logic [1:0]           bresp_ff;
   logic                 arready_ff;
   logic                 rvalid_ff;
   logic [1:0]           rresp_ff;
   logic [31:0]          rdata_ff;
   logic [ADDR_W-1:0]    waddr_ff;
   logic [31:0]          wdata_ff;
   logic [3:0]           wstrb_ff;
   logic                 have_aw_ff;
   logic                 have_w_ff;
   logic                 wr_go;
   logic                 wr_lane0;
   logic [3:0]           ctrl_ff;
   fbled_err_t           stat_ff;
   fbled_err_t           nxt_stat;
   fbled_err_t           stat_clr;
   fbled_err_t           stat_set;
   logic [4:0]           mask_ff;
   logic                 irq_ff;
   logic [NPORTS-1:0]    link_s1_ff;
   logic [NPORTS-1:0]    link_s2_ff;
   logic [NPORTS-1:0]    act_s1_ff;
   logic [NPORTS-1:0]    act_s2_ff;
   logic [NPORTS-1:0]    act_seen_ff;
   logic [NPORTS-1:0]    act_disp_ff;
   fbled_pat_t           pat;
   logic                 tick;
   fbled_al_state_t      al_state;
   logic                 fatal_now;
   logic                 run_green_ff;
   logic                 run_red_ff;
   logic                 err_red_ff;
   logic [NPORTS-1:0]    link_green_ff;
   logic                 passive_ff;

   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] o;
      o = 8'(a);
      addr_mapped = (o == `FBLED_OFS_CTRL) || (o == `FBLED_OFS_ERR_STAT) ||
                    (o == `FBLED_OFS_IRQ_MASK) || (o == `FBLED_OFS_LAMP_STAT);
   endfunction

   function automatic logic link_lamp(input logic link, input logic act, input logic flick);
      link_lamp = link & (~act | flick);
   endfunction

   // ***************************************************************
   // pattern source
   // ***************************************************************
   fbled_pattern_gen #(.TICK_CYCLES(TICK_CYCLES)) u_pat (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pat     (pat),
      .tick    (tick)
   );

   // ***************************************************************
   // axi4-lite write channels
   // ***************************************************************
   assign wr_go    = have_aw_ff && have_w_ff && !bvalid_ff;
   assign wr_lane0 = wr_go && wstrb_ff[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         have_aw_ff <= 1'b0;
         have_w_ff  <= 1'b0;
         waddr_ff   <= '0;
         wdata_ff   <= 32'h0;
         wstrb_ff   <= 4'h0;
      end else begin
         if (s_axi_awvalid && awready_ff) begin
            have_aw_ff <= 1'b1;
            awready_ff <= 1'b0;
            waddr_ff   <= s_axi_awaddr;
         end else if (wr_go) begin
            have_aw_ff <= 1'b0;
         end
         if (s_axi_wvalid && wready_ff) begin
            have_w_ff <= 1'b1;
            wready_ff <= 1'b0;
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
         end else if (wr_go) begin
            have_w_ff <= 1'b0;
         end
         if (bvalid_ff && s_axi_bready) begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= `FBLED_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= addr_mapped(waddr_ff) ? `FBLED_RESP_OKAY : `FBLED_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // ***************************************************************
   // software registers
   // ***************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff <= `FBLED_CTRL_RST;
         mask_ff <= `FBLED_MASK_RST;
      end else if (wr_lane0) begin
         if (8'(waddr_ff) == `FBLED_OFS_CTRL) begin
            ctrl_ff <= wdata_ff[3:0];
         end else if (8'(waddr_ff) == `FBLED_OFS_IRQ_MASK) begin
            mask_ff <= wdata_ff[4:0];
         end
      end
   end

   // write-one-to-clear, a new event in the same cycle wins
   always_comb begin
      stat_clr = '0;
      if (wr_lane0 && (8'(waddr_ff) == `FBLED_OFS_ERR_STAT)) begin
         stat_clr = fbled_err_t'(wdata_ff[4:0]);
      end
      stat_set = fbled_err_t'({evt_fatal, evt_boot_err, evt_wd_tmo, evt_unsol, evt_inv_cfg});
      nxt_stat = (stat_ff & ~stat_clr) | stat_set;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_ff <= `FBLED_ERR_RST;
         irq_ff  <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         irq_ff  <= |(5'(stat_ff) & mask_ff);
      end
   end

   // ***************************************************************
   // axi4-lite read channels
   // ***************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rresp_ff   <= `FBLED_RESP_OKAY;
         rdata_ff   <= 32'h0;
      end else if (s_axi_arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rresp_ff   <= addr_mapped(s_axi_araddr) ? `FBLED_RESP_OKAY : `FBLED_RESP_SLVERR;
         rdata_ff   <= 32'h0;
         if (8'(s_axi_araddr) == `FBLED_OFS_CTRL) begin
            rdata_ff[3:0] <= ctrl_ff;
         end else if (8'(s_axi_araddr) == `FBLED_OFS_ERR_STAT) begin
            rdata_ff[4:0] <= 5'(stat_ff);
         end else if (8'(s_axi_araddr) == `FBLED_OFS_IRQ_MASK) begin
            rdata_ff[4:0] <= mask_ff;
         end else if (8'(s_axi_araddr) == `FBLED_OFS_LAMP_STAT) begin
            rdata_ff[`FBLED_LAMP_RUN_G]   <= run_green_ff;
            rdata_ff[`FBLED_LAMP_RUN_R]   <= run_red_ff;
            rdata_ff[`FBLED_LAMP_ERR_R]   <= err_red_ff;
            rdata_ff[`FBLED_LAMP_PASSIVE] <= passive_ff;
            rdata_ff[`FBLED_LAMP_LINK_LSB +: NPORTS] <= link_green_ff;
         end
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   // ***************************************************************
   // phy pin synchronisers and activity capture
   // ***************************************************************
   // short traffic bursts are held for a whole pattern tick
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link_s1_ff  <= '0;
         link_s2_ff  <= '0;
         act_s1_ff   <= '0;
         act_s2_ff   <= '0;
         act_seen_ff <= '0;
         act_disp_ff <= '0;
      end else begin
         link_s1_ff  <= link_pin;
         link_s2_ff  <= link_s1_ff;
         act_s1_ff   <= act_pin;
         act_s2_ff   <= act_s1_ff;
         act_seen_ff <= act_s2_ff | (act_seen_ff & {NPORTS{~tick}});
         if (tick) begin
            act_disp_ff <= act_seen_ff | act_s2_ff;
         end
      end
   end

   // ***************************************************************
   // run lamp and bus passive
   // ***************************************************************
   assign al_state  = fbled_al_state_t'(ctrl_ff[`FBLED_CTRL_STATE_LSB +: `FBLED_CTRL_STATE_W]);
   assign fatal_now = stat_ff.fatal | ctrl_ff[`FBLED_CTRL_APPFAIL];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_green_ff <= 1'b0;
         run_red_ff   <= 1'b0;
         passive_ff   <= 1'b0;
      end else if (fatal_now) begin
         run_green_ff <= 1'b0;
         run_red_ff   <= 1'b1;
         passive_ff   <= 1'b1;
      end else begin
         run_red_ff <= 1'b0;
         passive_ff <= 1'b0;
         case (al_state)
            FBLED_INIT:   run_green_ff <= 1'b0;
            FBLED_OP:     run_green_ff <= 1'b1;
            FBLED_PREOP:  run_green_ff <= pat.blink;
            FBLED_SAFEOP: run_green_ff <= pat.sflash;
            FBLED_BOOT:   run_green_ff <= pat.flicker;
            default:      run_green_ff <= 1'b0;
         endcase
      end
   end

   // ***************************************************************
   // error lamp, most severe pending condition first
   // ***************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_red_ff <= 1'b0;
      end else if (fatal_now) begin
         err_red_ff <= 1'b1;
      end else if (stat_ff.boot_err) begin
         err_red_ff <= pat.flicker;
      end else if (stat_ff.wd_tmo) begin
         err_red_ff <= pat.dflash;
      end else if (stat_ff.unsol) begin
         err_red_ff <= pat.sflash;
      end else if (stat_ff.inv_cfg) begin
         err_red_ff <= pat.blink;
      end else begin
         err_red_ff <= 1'b0;
      end
   end

   // ***************************************************************
   // link and activity lamps
   // ***************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link_green_ff <= '0;
      end else begin
         for (int i = 0; i < NPORTS; i++) begin
            link_green_ff[i] <= link_lamp(link_s2_ff[i], act_disp_ff[i],
                                          pat.flicker);
         end
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rresp   = rresp_ff;
   assign s_axi_rdata   = rdata_ff;
   assign run_green     = run_green_ff;
   assign run_red       = run_red_ff;
   assign err_red       = err_red_ff;
   assign link_green    = link_green_ff;
   assign bus_passive   = passive_ff;
   assign irq           = irq_ff;

endmodule

`default_nettype wire

/* tb/fbled_asserts.sv */
// port checker for the fieldbus slave lamp block
`timescale 1ns/1ps
`default_nettype none

module fbled_asserts #(
   parameter int unsigned NPORTS      = 2,
   parameter int unsigned ADDR_W      = 8,
   parameter int unsigned TICK_CYCLES = 8
) (
   // clock and reset
   input wire logic              aclk,
   input wire logic              aresetn,
   // register bus
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   // status inputs and lamps
   input wire logic              evt_fatal,
   input wire logic [NPORTS-1:0] link_pin,
   input wire logic [NPORTS-1:0] act_pin,
   input wire logic              run_green,
   input wire logic              run_red,
   input wire logic              err_red,
   input wire logic [NPORTS-1:0] link_green,
   input wire logic              bus_passive
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // cycles that port 0 has shown link without traffic
   logic [31:0] calm_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn || !link_pin[0] || act_pin[0]) begin
         calm_ff <= 32'h0;
      end else if (calm_ff != 32'hffff_ffff) begin
         calm_ff <= calm_ff + 32'h1;
      end
   end

   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   chk_fatal_lamps: assert property (
      run_red == bus_passive && (!run_red || (err_red && !run_green)))
      else $error("fatal lamp group inconsistent");
   chk_fatal_event: assert property (evt_fatal |-> ##2 run_red)
      else $error("fatal event not shown two edges later");
   chk_link_dark: assert property (!link_pin[0] [*4] |-> !link_green[0])
      else $error("link lamp lit without link");
   chk_link_steady: assert property (calm_ff > 4 * TICK_CYCLES + 8 |-> link_green[0])
      else $error("link lamp not steady on idle link");
   chk_write_answer: assert property (s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response not on second edge");
   chk_write_unmapped: assert property (
      s_wr_taken ##0 s_axi_awaddr[7:4] != 4'h0 |=> ##1 s_axi_bresp == 2'b10)
      else $error("unmapped write not refused");
   chk_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
      else $error("read data not one edge after address");
   chk_read_unmapped: assert property (s_rd_taken ##0 s_axi_araddr[7:4] != 4'h0
      |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule

bind fbled_top fbled_asserts #(.NPORTS(NPORTS), .ADDR_W(ADDR_W), .TICK_CYCLES(TICK_CYCLES))
   u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .evt_fatal, .link_pin, .act_pin, .run_green,
   .run_red, .err_red, .link_green, .bus_passive);

`default_nettype wire

/* tb/fbled_phy_model.sv */
// far side stand-in: link and traffic seen per port
`timescale 1ns/1ps
`default_nettype none

module fbled_phy_model #(
   parameter int unsigned NPORTS = 2
) (
   // clock
   input  wire logic                  aclk,
   // per port: 0 no link, 1 idle link, 2 link with traffic
   input  wire logic [2*NPORTS-1:0]   mode,
   // status pins
   output var logic [NPORTS-1:0]      link_pin = '0,
   output var logic [NPORTS-1:0]      act_pin = '0
);
   logic [1:0] ph_ff = 2'h0;

   // short frames every fourth cycle while traffic runs
   always @(posedge aclk) begin
      ph_ff <= ph_ff + 2'h1;
      for (int i = 0; i < NPORTS; i++) begin
         link_pin[i] <= mode[2*i +: 2] != 2'h0;
         act_pin[i]  <= mode[2*i +: 2] == 2'h2 && ph_ff == 2'h0;
      end
   end
endmodule

`default_nettype wire

/* tb/test_fieldbus_slave_led_indicator.sv */
// self-checking bench for the fieldbus slave lamp block
`timescale 1ns/1ps
`default_nettype none

module test_fieldbus_slave_led_indicator;
   localparam int T = 8;
   localparam int F = 24 * T;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'he72d49df;
   logic [3:0]  s_axi_wstrb = 4'hf, mode = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, link_pin, act_pin, link_green;
   logic        run_green, run_red, err_red, bus_passive, irq;
   logic [4:0]  evt = 5'h00;
   logic [2:0]  st[6] = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h6, 3'h7};
   int          n_errors = 0, comparisons = 0, m_err = 0, m_mask = 0;
   int          e_on[6] = '{0, F, F / 2, F / 6, F / 3, F / 2};
   int          e_rise[6] = '{0, 0, 3, 1, 2, 12};
   int          sp[6] = '{0, 1, 2, 3, 5, 0};
   int          ep[5] = '{2, 3, 4, 5, 1};
   int          lp[3] = '{0, 1, 5};
   wire [3:0]   lamps = {link_green, err_red, run_green};

   always #5 aclk = ~aclk;

   fbled_phy_model phy (.aclk, .mode, .link_pin, .act_pin);
   fbled_top #(.TICK_CYCLES(T)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .evt_inv_cfg(evt[0]),
      .evt_unsol(evt[1]), .evt_wd_tmo(evt[2]), .evt_boot_err(evt[3]), .evt_fatal(evt[4]),
      .link_pin, .act_pin, .run_green, .run_red, .err_red, .link_green, .bus_passive, .irq);

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic guard(input int n);
      if (n >= 40) begin
         n_errors++;
         complete_run();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 40);
      guard(n);
      check(s_axi_bresp, er);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 40);
      guard(n);
      check(s_axi_rdata, ed);
      check(s_axi_rresp, er);
   endtask

   // counts lit cycles and rising edges of one lamp over a whole frame
   task automatic pat(input int which, input int p);
      int   on, rise;
      logic prev;
      on = 0;
      rise = 0;
      repeat (3 * T) @(posedge aclk);
      prev = lamps[which];
      repeat (F) begin
         @(posedge aclk);
         if ($isunknown(lamps[which])) on += F;
         if (lamps[which] === 1'b1) on++;
         if (lamps[which] === 1'b1 && prev === 1'b0) rise++;
         prev = lamps[which];
      end
      check(on, e_on[p]);
      check(rise, e_rise[p]);
   endtask

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int a = 0; a < 16; a += 4) rd(a[7:0], 32'h0, 2'b00);
      wr(8'h20, seed, 2'b10);
      rd(8'h20, 32'h0, 2'b10);
      seed = lfsr(seed);
      m_mask = int'(seed[4:0]);
      wr(8'h08, seed, 2'b00);
      rd(8'h08, m_mask, 2'b00);
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         wr(8'h00, {seed[31:4], 1'b0, st[i]}, 2'b00);
         rd(8'h00, {29'h0, st[i]}, 2'b00);
         pat(0, sp[i]);
      end
      for (int i = 0; i < 5; i++) begin
         evt <= 5'h01 << i;
         @(posedge aclk);
         evt <= 5'h00;
         m_err |= 1 << i;
         repeat (2) @(posedge aclk);
         check(irq, (m_err & m_mask) != 0);
         rd(8'h04, m_err, 2'b00);
         pat(1, ep[i]);
      end
      rd(8'h0c, 32'he, 2'b00);
      wr(8'h04, 32'h10, 2'b00);
      m_err = 15;
      rd(8'h04, m_err, 2'b00);
      pat(1, 5);
      check(irq, (m_err & m_mask) != 0);
      wr(8'h04, 32'h1f, 2'b00);
      rd(8'h04, 32'h0, 2'b00);
      pat(1, 0);
      check(irq, 32'h0);
      wr(8'h00, 32'h8, 2'b00);
      rd(8'h0c, 32'he, 2'b00);
      wr(8'h00, 32'h0, 2'b00);
      rd(8'h0c, 32'h0, 2'b00);
      for (int m = 0; m < 3; m++) begin
         mode <= {2'(m), 2'(2 - m)};
         pat(2, lp[2 - m]);
         pat(3, lp[m]);
      end
      complete_run();
   end
endmodule

`default_nettype wire
